/* File: design/crd_reg_bank.sv */
// Contract
// R1: Register space lives in the two-BAR window.
// R2: Host maps window ordered, variable width.
// R3: Host should map window uncacheable.
// R4: Host never issues locked accesses.
// R5: Host uses native or aligned 32-bit accesses.
// R6: Accesses spanning two registers are unsupported.
// R7: Undefined space and reserved bits read zero.
// R8: Software must not rely on zero reads.
// R9: Optional subsystem reset register at 20h.
// R10: Admin submit base, 64 bits at 28h.
// R11: Admin complete base, 64 bits at 30h.
// R12: Admin tail doorbell fixed at 1000h.
// R13: Tail doorbell y at 1000h + 2y units.
// R14: Head doorbell y at 1000h + (2y+1) units.
// R15: Admin head doorbell one unit above 1000h.
// R16: Read-only stride field sets doorbell spacing.
// R17: Writes to read-only or undefined space ignored.
// R18: Doorbells past implemented queues are undefined.
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_reg_bank import crd_pkg::*; #(
   parameter logic [3:0] STRIDE = 4'h0,
   parameter int NUM_IOQ = 1,
   parameter bit SSR_EN = 1'b1,
   parameter logic [63:0] CAP_BASE = 64'h0000_0000_0000_0000,
   parameter logic [31:0] VERSION = 32'h0001_0000
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [31:0] i_mem_base_low,
   input wire logic [31:0] i_mem_base_high,
   input wire logic i_mem_rd,
   input wire logic i_mem_wr,
   input wire logic i_mem_size,
   input wire logic i_mem_lock,
   input wire logic [63:0] i_mem_addr,
   input wire logic [63:0] i_mem_wdata,
   input wire logic [31:0] i_ctrl_state,
   output logic [63:0] o_mem_rdata,
   output logic o_mem_rvalid,
   output logic [31:0] o_irq_mask,
   output logic [31:0] o_cc,
   output logic [31:0] o_aqa,
   output logic [63:0] o_asq,
   output logic [63:0] o_acq,
   output logic o_bell_valid,
   output logic [15:0] o_bell_index,
   output logic [15:0] o_bell_value,
   output logic o_ssr_valid,
   output logic [31:0] o_ssr_value
);

   crd_state_s st_ff;
   crd_state_s nxt_st;
   logic [63:0] cap_val;
   logic [63:0] win_base;
   logic [15:0] off;
   logic hit;
   logic legal;
   logic bell_hit;
   logic [15:0] bell_idx;
   logic rd_go;
   logic wr_go;

   // The stride is a fixed capability; software reads it but cannot move it.
   always_comb begin
      cap_val = CAP_BASE;
      cap_val[`CRD_CAP_STRD_LSB +: 4] = STRIDE; // R16
      cap_val[`CRD_CAP_SSRS_BIT] = SSR_EN;
   end

   // BAR0 low bits carry memory type flags, so they never join the compare.
   assign win_base = {i_mem_base_high, i_mem_base_low};
   assign hit = i_mem_addr[63:`CRD_WIN_BITS] == win_base[63:`CRD_WIN_BITS]; // R1
   assign off = i_mem_addr[15:0];

   function automatic logic is_wide(input logic [15:0] o);
      is_wide = (o == `CRD_OFS_CAP) || (o == `CRD_OFS_ASQ) || (o == `CRD_OFS_ACQ);
   endfunction

   function automatic logic [31:0] rd_word(input logic [15:0] o);
      case (o)
         `CRD_OFS_CAP: rd_word = cap_val[31:0];
         `CRD_OFS_CAP + `CRD_OFS_HI: rd_word = cap_val[63:32];
         `CRD_OFS_VS: rd_word = VERSION;
         `CRD_OFS_IRQ_MASK_SET: rd_word = st_ff.mask;
         `CRD_OFS_IRQ_MASK_CLEAR: rd_word = st_ff.mask;
         `CRD_OFS_CC: rd_word = st_ff.cc;
         `CRD_OFS_CONTROLLER_STATE: rd_word = i_ctrl_state;
         `CRD_OFS_SSR: rd_word = SSR_EN ? st_ff.ssr : `CRD_RST_32; // R9
         `CRD_OFS_AQA: rd_word = st_ff.admin_queue_sizes;
         `CRD_OFS_ASQ: rd_word = st_ff.admin_submit_base[31:0];
         `CRD_OFS_ASQ + `CRD_OFS_HI: rd_word = st_ff.admin_submit_base[63:32];
         `CRD_OFS_ACQ: rd_word = st_ff.admin_complete_base[31:0];
         `CRD_OFS_ACQ + `CRD_OFS_HI: rd_word = st_ff.admin_complete_base[63:32];
         // Doorbells are write-only and the reserved gaps hold nothing.
         default: rd_word = `CRD_RST_32; // R7
      endcase
   endfunction

   crd_bell_decode #(
      .NQ(NUM_IOQ + 1)
   ) u_bell (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_off(off),
      .i_stride(STRIDE),
      .o_hit(bell_hit),
      .o_index(bell_idx)
   );

   // Only native width or an aligned dword is honoured; a qword that would
   // straddle two registers is dropped rather than half applied.
   always_comb begin
      if (i_mem_size == CRD_SZ_64) begin
         legal = (off[2:0] == 3'h0) && is_wide(off); // R5 R6
      end else begin
         legal = off[1:0] == 2'h0; // R5
      end
   end

   assign rd_go = i_mem_rd && hit;
   // A locked cycle carries no defined meaning here, so its write is dropped.
   assign wr_go = i_mem_wr && hit && legal && !i_mem_lock; // R4

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rvalid = rd_go;
      nxt_st.bell_v = 1'b0;
      nxt_st.ssr_v = 1'b0;
      if (rd_go) begin
         if (!legal) begin
            nxt_st.rdata = `CRD_RST_64; // R6
         end else if (i_mem_size == CRD_SZ_64) begin
            nxt_st.rdata = {rd_word(off + `CRD_OFS_HI), rd_word(off)}; // R10 R11
         end else begin
            nxt_st.rdata = {32'h0000_0000, rd_word(off)}; // R7
         end
      end
      if (wr_go && i_mem_size == CRD_SZ_64) begin
         case (off)
            `CRD_OFS_ASQ: nxt_st.admin_submit_base = i_mem_wdata; // R10
            `CRD_OFS_ACQ: nxt_st.admin_complete_base = i_mem_wdata; // R11
            default: nxt_st.admin_submit_base = st_ff.admin_submit_base; // R17
         endcase
      end else if (wr_go) begin
         case (off)
            `CRD_OFS_IRQ_MASK_SET: nxt_st.mask = st_ff.mask | i_mem_wdata[31:0];
            `CRD_OFS_IRQ_MASK_CLEAR: nxt_st.mask = st_ff.mask & ~i_mem_wdata[31:0];
            `CRD_OFS_CC: nxt_st.cc = i_mem_wdata[31:0];
            `CRD_OFS_SSR: begin
               if (SSR_EN) begin
                  nxt_st.ssr = i_mem_wdata[31:0]; // R9
                  nxt_st.ssr_v = 1'b1;
               end
            end
            `CRD_OFS_AQA: nxt_st.admin_queue_sizes = i_mem_wdata[31:0];
            `CRD_OFS_ASQ: nxt_st.admin_submit_base[31:0] = i_mem_wdata[31:0]; // R10
            `CRD_OFS_ASQ + `CRD_OFS_HI: nxt_st.admin_submit_base[63:32] = i_mem_wdata[31:0]; // R10
            `CRD_OFS_ACQ: nxt_st.admin_complete_base[31:0] = i_mem_wdata[31:0]; // R11
            `CRD_OFS_ACQ + `CRD_OFS_HI: nxt_st.admin_complete_base[63:32] = i_mem_wdata[31:0]; // R11
            default: begin
               // Anything else that is not a live doorbell slot is silently ignored.
               if (bell_hit) begin // R12 R13 R14 R15 R18
                  nxt_st.bell_v = 1'b1;
                  nxt_st.bell_q = bell_idx;
                  nxt_st.bell_val = i_mem_wdata[`CRD_BELL_W-1:0];
               end // R17
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_mem_rdata = st_ff.rdata;
   assign o_mem_rvalid = st_ff.rvalid;
   assign o_irq_mask = st_ff.mask;
   assign o_cc = st_ff.cc;
   assign o_aqa = st_ff.admin_queue_sizes;
   assign o_asq = st_ff.admin_submit_base;
   assign o_acq = st_ff.admin_complete_base;
   assign o_bell_valid = st_ff.bell_v;
   assign o_bell_index = st_ff.bell_q;
   assign o_bell_value = st_ff.bell_val;
   assign o_ssr_valid = st_ff.ssr_v;
   assign o_ssr_value = st_ff.ssr;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   window_miss_a: assert property ((i_mem_wr && !hit) |=> // R1
      ($stable(st_ff.cc) && $stable(st_ff.admin_submit_base) && !o_bell_valid))
      else $error("write outside the window changed state");
   read_answer_a: assert property ((i_mem_rd && hit) |=> o_mem_rvalid) // R1
      else $error("read answer missing");
   span_read_a: assert property ((rd_go && !legal) |=> (o_mem_rvalid && o_mem_rdata == 64'h0)) // R6
      else $error("straddling read did not return zero");
   reserved_zero_a: assert property ((rd_go && off == `CRD_OFS_RSVD && legal) |=> // R7
      (o_mem_rdata == 64'h0))
      else $error("reserved location read nonzero");
   ssr_opt_a: assert property ((wr_go && off == `CRD_OFS_SSR && i_mem_size == CRD_SZ_32) |=> // R9
      (o_ssr_valid == SSR_EN))
      else $error("subsystem reset write mishandled");
   asq_write_a: assert property ((wr_go && off == `CRD_OFS_ASQ && i_mem_size == CRD_SZ_64) |=> // R10
      (o_asq == $past(i_mem_wdata)))
      else $error("admin submit base not written");
   acq_high_a: assert property ((wr_go && off == 16'h0034 && i_mem_size == CRD_SZ_32) |=> // R11
      (o_acq[63:32] == $past(i_mem_wdata[31:0]) && $stable(o_acq[31:0])))
      else $error("admin complete base high half wrong");
   admin_bell_a: assert property ((wr_go && off == `CRD_OFS_BELL && i_mem_size == CRD_SZ_32) |=> // R12
      (o_bell_valid && o_bell_index == 16'h0000))
      else $error("admin tail doorbell write lost");
   stride_field_a: assert property ((rd_go && legal && off == `CRD_OFS_CAP && i_mem_size == CRD_SZ_64) |=> // R16
      (o_mem_rdata[35:32] == STRIDE))
      else $error("stride field wrong");
   ro_write_a: assert property ((i_mem_wr && hit && off == `CRD_OFS_CAP) |=> // R17
      ($stable(st_ff.mask) && $stable(st_ff.cc) && $stable(st_ff.admin_queue_sizes) && !o_bell_valid))
      else $error("write to read-only space had a side effect");
   bell_pulse_a: assert property (o_bell_valid |=> !o_bell_valid || $past(wr_go, 1)) // R13
      else $error("doorbell pulse stretched");

   // The admin head doorbell moves with the stride, unlike the admin tail.
   admin_head_a: assert property ((wr_go && i_mem_size == CRD_SZ_32 &&
      off == 16'(`CRD_OFS_BELL + (16'h0004 << STRIDE))) |=> // R15
      (o_bell_valid && o_bell_index == 16'h0001))
      else $error("admin head doorbell not at one stride unit");
   bell_data_a: assert property ((wr_go && bell_hit && i_mem_size == CRD_SZ_32) |=> // R14
      (o_bell_value == $past(i_mem_wdata[15:0]) && o_bell_index == $past(bell_idx)))
      else $error("doorbell value or slot not captured");
   bell_gap_a: assert property ((i_mem_wr && !bell_hit && off >= `CRD_OFS_BELL) |=> // R18
      !o_bell_valid)
      else $error("doorbell pulse for an unimplemented slot");
   bell_quiet_a: assert property (!wr_go |=> !o_bell_valid) // R17
      else $error("doorbell pulse without a write");

   // Refused writes must leave every stored register exactly as it was.
   lock_drop_a: assert property ((i_mem_wr && i_mem_lock) |=> // R4
      ($stable(st_ff.cc) && $stable(st_ff.admin_submit_base) && $stable(st_ff.admin_complete_base) && !o_bell_valid))
      else $error("locked write was applied");
   misalign_drop_a: assert property ((i_mem_wr && hit && i_mem_size == CRD_SZ_32 &&
      off[1:0] != 2'h0) |=> // R5
      ($stable(st_ff.cc) && $stable(st_ff.mask) && $stable(st_ff.admin_queue_sizes) && !o_bell_valid))
      else $error("misaligned dword write was applied");
   wide_span_a: assert property ((i_mem_wr && hit && i_mem_size == CRD_SZ_64 &&
      !is_wide(off)) |=> // R6
      ($stable(st_ff.admin_submit_base) && $stable(st_ff.admin_complete_base) && $stable(st_ff.cc) && !o_bell_valid))
      else $error("straddling qword write was applied");
   ro_version_a: assert property ((i_mem_wr && hit && off == `CRD_OFS_VS) |=> // R17
      ($stable(st_ff.mask) && $stable(st_ff.cc) && $stable(st_ff.ssr) && !o_ssr_valid))
      else $error("write to the version register had a side effect");

   // Read data carries only what the addressed register holds.
   undef_read_a: assert property ((rd_go && legal && i_mem_size == CRD_SZ_32 &&
      off >= 16'h0038) |=> // R7
      (o_mem_rdata == 64'h0))
      else $error("undefined or doorbell location read nonzero");
   high_zero_a: assert property ((rd_go && i_mem_size == CRD_SZ_32) |=> // R7
      (o_mem_rdata[63:32] == 32'h0))
      else $error("dword read left upper half nonzero");
   rvalid_pulse_a: assert property (!(i_mem_rd && hit) |=> !o_mem_rvalid) // R1
      else $error("read answer without a read");
   rdata_hold_a: assert property (!(i_mem_rd && hit) |=> $stable(o_mem_rdata))
      else $error("read data changed without a read");

   // Register writes, in the low half and at full width.
   asq_low_a: assert property ((wr_go && off == `CRD_OFS_ASQ && i_mem_size == CRD_SZ_32) |=> // R10
      (o_asq[31:0] == $past(i_mem_wdata[31:0]) && $stable(o_asq[63:32])))
      else $error("admin submit base low half wrong");
   acq_wide_a: assert property ((wr_go && off == `CRD_OFS_ACQ && i_mem_size == CRD_SZ_64) |=> // R11
      (o_acq == $past(i_mem_wdata)))
      else $error("admin complete base not written");
   ssr_value_a: assert property ((wr_go && off == `CRD_OFS_SSR && i_mem_size == CRD_SZ_32 &&
      SSR_EN) |=> // R9
      (o_ssr_value == $past(i_mem_wdata[31:0])))
      else $error("subsystem reset value not captured");
   ssr_quiet_a: assert property (!wr_go |=> !o_ssr_valid) // R9
      else $error("subsystem reset pulse without a write");
   cc_write_a: assert property ((wr_go && off == `CRD_OFS_CC && i_mem_size == CRD_SZ_32) |=>
      (o_cc == $past(i_mem_wdata[31:0])))
      else $error("configuration write lost");
   aqa_write_a: assert property ((wr_go && off == `CRD_OFS_AQA && i_mem_size == CRD_SZ_32) |=>
      (o_aqa == $past(i_mem_wdata[31:0])))
      else $error("admin queue sizes write lost");
   mask_set_a: assert property ((wr_go && off == `CRD_OFS_IRQ_MASK_SET && i_mem_size == CRD_SZ_32) |=>
      (o_irq_mask == ($past(st_ff.mask) | $past(i_mem_wdata[31:0]))))
      else $error("mask set did not or in the written ones");
   mask_clear_a: assert property ((wr_go && off == `CRD_OFS_IRQ_MASK_CLEAR && i_mem_size == CRD_SZ_32) |=>
      (o_irq_mask == ($past(st_ff.mask) & ~$past(i_mem_wdata[31:0]))))
      else $error("mask clear did not remove the written ones");

   // Scenarios worth seeing at least once in any run.
   span_read_c: cover property (rd_go && !legal);
   asq_wide_c: cover property (wr_go && off == `CRD_OFS_ASQ && i_mem_size == CRD_SZ_64);
   io_bell_c: cover property (o_bell_valid && o_bell_index > 16'h0001);
   ssr_c: cover property (o_ssr_valid);
   mask_c: cover property (wr_go && off == `CRD_OFS_IRQ_MASK_CLEAR ##1 o_irq_mask != 32'h0);

endmodule
`default_nettype wire

/* File: design/crd_params.svh */
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH

// Address window: the controller space takes 64 KB of the memory window.
`define CRD_WIN_BITS 16

// Register byte offsets inside the controller space.
`define CRD_OFS_CAP 16'h0000
`define CRD_OFS_VS 16'h0008
`define CRD_OFS_IRQ_MASK_SET 16'h000C
`define CRD_OFS_IRQ_MASK_CLEAR 16'h0010
`define CRD_OFS_CC 16'h0014
`define CRD_OFS_RSVD 16'h0018
`define CRD_OFS_CONTROLLER_STATE 16'h001C
`define CRD_OFS_SSR 16'h0020
`define CRD_OFS_AQA 16'h0024
`define CRD_OFS_ASQ 16'h0028
`define CRD_OFS_ACQ 16'h0030
`define CRD_OFS_BELL 16'h1000
`define CRD_OFS_HI 16'h0004

// Field positions inside the feature info register.
`define CRD_CAP_STRD_LSB 32
`define CRD_CAP_SSRS_BIT 36

// Reset values of the writable registers.
`define CRD_RST_32 32'h0000_0000
`define CRD_RST_64 64'h0000_0000_0000_0000

// Doorbell value width and the byte shift of one stride unit (4 bytes).
`define CRD_BELL_W 16
`define CRD_UNIT_SH 5'h02

`endif

/* File: design/crd_pkg.sv */
package crd_pkg;

   typedef enum logic {
      CRD_SZ_32 = 1'b0,
      CRD_SZ_64 = 1'b1
   } crd_size_e;

   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] cc;
      logic [31:0] ssr;
      logic [31:0] admin_queue_sizes;
      logic [63:0] admin_submit_base;
      logic [63:0] admin_complete_base;
      logic [63:0] rdata;
      logic rvalid;
      logic bell_v;
      logic [15:0] bell_q;
      logic [15:0] bell_val;
      logic ssr_v;
   } crd_state_s;

endpackage

/* File: design/crd_bell_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_bell_decode import crd_pkg::*; #(
   parameter int NQ = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [15:0] i_off,
   input wire logic [3:0] i_stride,
   output logic o_hit,
   output logic [15:0] o_index
);

   logic [15:0] rel;
   logic [4:0] sh;
   logic [16:0] limit;
   logic aligned;

   // The stride unit is 4 << stride bytes; even slots are tails, odd are heads.
   always_comb begin
      rel = i_off - `CRD_OFS_BELL;
      sh = {1'b0, i_stride} + `CRD_UNIT_SH;
      o_index = rel >> sh; // R13 R14 R15
      aligned = (rel & ((16'h0001 << sh) - 16'h0001)) == 16'h0000;
      limit = 17'(2 * NQ);
      // Slots past the implemented queues fall back to undefined space.
      o_hit = (i_off >= `CRD_OFS_BELL) && aligned && ({1'b0, o_index} < limit); // R12 R18
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   admin_tail_slot_a: assert property ((i_off == `CRD_OFS_BELL) |-> (o_hit && o_index == 16'h0000)) // R12
      else $error("admin tail doorbell not decoded as slot 0");
   bell_position_a: assert property (o_hit |->
      (i_off == 16'(`CRD_OFS_BELL + (o_index << sh)))) // R13
      else $error("doorbell slot does not match stride spacing");
   bell_range_a: assert property (o_hit |-> ({1'b0, o_index} < limit)) // R18
      else $error("doorbell slot beyond implemented queues");

endmodule
`default_nettype wire

/* File: tb/crd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module crd_host_model (
   input wire logic i_ref_clk,
   input wire logic i_mem_rvalid,
   input wire logic [63:0] i_mem_rdata,
   input wire logic i_bell_valid,
   input wire logic i_ssr_valid,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic o_mem_size,
   output logic o_mem_lock,
   output logic [63:0] o_mem_addr,
   output logic [63:0] o_mem_wdata
);
   initial begin
      o_mem_rd = 1'b0;
      o_mem_wr = 1'b0;
      o_mem_size = 1'b0;
      o_mem_lock = 1'b0;
      o_mem_addr = 64'h0;
      o_mem_wdata = 64'h0;
   end

   // One access at a time, so the window sees strictly ordered traffic.
   // Zero reads of reserved space are checked by the bench, never used as data.
   // Released address and data lines carry the inverse of the last value, so stale data never looks valid.
   task automatic access(input logic wr, input logic sz, input logic lk, input logic [63:0] adr,
         input logic [63:0] wd, output logic [63:0] rdv, output logic [2:0] seen);
      @(posedge i_ref_clk);
      o_mem_rd <= !wr;
      o_mem_wr <= wr;
      o_mem_size <= sz;
      o_mem_lock <= lk;
      o_mem_addr <= adr;
      o_mem_wdata <= wd;
      @(posedge i_ref_clk);
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_lock <= 1'b0;
      o_mem_addr <= ~adr;
      o_mem_wdata <= ~wd;
      // The answer stands for the cycle after the taking edge, so look mid-cycle.
      @(negedge i_ref_clk);
      rdv = i_mem_rdata;
      seen = {i_mem_rvalid, i_bell_valid, i_ssr_valid};
   endtask
endmodule

`default_nettype wire

/* File: tb/crd_reg_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module crd_reg_bank_bench;
   import crd_pkg::*;
   localparam logic [63:0] BASE = 64'h0000_0001_FE00_0000;
   localparam logic [63:0] CAP_EXP = 64'h0000_0011_0000_0000;
   logic i_ref_clk, i_resetn, rd, wr, sz, lk, rv, bv, sv;
   logic [63:0] adr, wd, rdata, admin_submit_base, admin_complete_base;
   logic [31:0] mask, cc, admin_queue_sizes, ssr;
   logic [15:0] bidx, bval;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [63:0] v;
   logic [2:0] seen;

   crd_reg_bank #(.STRIDE(4'h1), .NUM_IOQ(1), .SSR_EN(1'b1)) i_crd_reg_bank (
      .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mem_base_low(BASE[31:0]),
      .i_mem_base_high(BASE[63:32]), .i_mem_rd(rd), .i_mem_wr(wr), .i_mem_size(sz),
      .i_mem_lock(lk), .i_mem_addr(adr), .i_mem_wdata(wd), .i_ctrl_state(32'h0000_0009),
      .o_mem_rdata(rdata), .o_mem_rvalid(rv), .o_irq_mask(mask), .o_cc(cc), .o_aqa(admin_queue_sizes),
      .o_asq(admin_submit_base), .o_acq(admin_complete_base), .o_bell_valid(bv), .o_bell_index(bidx),
      .o_bell_value(bval), .o_ssr_valid(sv), .o_ssr_value(ssr));

   crd_host_model i_crd_host_model (
      .i_ref_clk(i_ref_clk), .i_mem_rvalid(rv), .i_mem_rdata(rdata), .i_bell_valid(bv),
      .i_ssr_valid(sv), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_size(sz), .o_mem_lock(lk),
      .o_mem_addr(adr), .o_mem_wdata(wd));

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrr(input logic [15:0] off, input logic [63:0] d, input logic s = 1'b0,
         input logic l = 1'b0);
      i_crd_host_model.access(1'b1, s, l, BASE + 64'(off), d, v, seen);
   endtask

   task automatic rdc(input logic [15:0] off, input logic s, input logic [63:0] exp);
      i_crd_host_model.access(1'b0, s, 1'b0, BASE + 64'(off), 64'h0, v, seen);
      chk("rvalid", 64'h1, 64'(seen[2]));
      chk($sformatf("read %h", off), exp, v);
   endtask

   task automatic t_ident;
      chk("cc at reset", 64'h0, 64'(cc));
      chk("asq at reset", 64'h0, admin_submit_base);
      rdc(16'h0000, 1'b1, CAP_EXP);
      rdc(16'h0008, 1'b0, 64'h0000_0000_0001_0000);
      rdc(16'h001C, 1'b0, 64'h0000_0000_0000_0009);
   endtask

   task automatic t_rw;
      wrr(16'h0014, 64'hA5A5_0001);
      wrr(16'h0024, 64'h001F_001F);
      wrr(16'h0020, 64'h4E56_4D65);
      chk("ssr pulse", 64'h1, 64'(seen[0]));
      chk("ssr value", 64'h4E56_4D65, 64'(ssr));
      wrr(16'h0028, 64'h1234_5678_9ABC_D000, 1'b1);
      wrr(16'h0030, 64'h0000_E000);
      wrr(16'h0034, 64'h0000_00AB);
      rdc(16'h0028, 1'b1, 64'h1234_5678_9ABC_D000);
      rdc(16'h002C, 1'b0, 64'h1234_5678);
      rdc(16'h0030, 1'b1, 64'h0000_00AB_0000_E000);
      rdc(16'h0014, 1'b0, 64'hA5A5_0001);
      rdc(16'h0024, 1'b0, 64'h001F_001F);
      chk("aqa out", 64'h001F_001F, 64'(admin_queue_sizes));
      chk("acq out", 64'h0000_00AB_0000_E000, admin_complete_base);
   endtask

   task automatic t_ro;
      logic [15:0] offs [5] = '{16'h0000, 16'h0008, 16'h0018, 16'h0038, 16'h0F00};
      foreach (offs[i]) wrr(offs[i], 64'hFFFF_FFFF);
      rdc(16'h0000, 1'b1, CAP_EXP);
      rdc(16'h0008, 1'b0, 64'h0001_0000);
      for (int i = 2; i < 5; i++) rdc(offs[i], 1'b0, 64'h0);
      rdc(16'h1008, 1'b0, 64'h0);
      chk("cc kept", 64'hA5A5_0001, 64'(cc));
   endtask

   task automatic t_bell;
      // With a stride field of 1 each slot is 8 bytes apart; slot 4 is past the last queue.
      for (int k = 0; k < 5; k++) begin
         wrr(16'h1000 + 16'(k * 8), 64'h0100 + 64'(k));
         chk("bell pulse", 64'(k < 4), 64'(seen[1]));
         if (k < 4) begin
            chk("bell index", 64'(k), 64'(bidx));
            chk("bell value", 64'h0100 + 64'(k), 64'(bval));
         end
      end
      wrr(16'h1004, 64'h77);
      chk("gap bell", 64'h0, 64'(seen[1]));
   endtask

   task automatic t_refuse;
      wrr(16'h0014, 64'h1, 1'b0, 1'b1);
      wrr(16'h0016, 64'h2);
      wrr(16'h002C, 64'hDEAD_BEEF_CAFE_F00D, 1'b1);
      i_crd_host_model.access(1'b1, 1'b0, 1'b0, BASE + 64'h1_0000_0014, 64'h3, v, seen);
      chk("cc refused", 64'hA5A5_0001, 64'(cc));
      chk("asq refused", 64'h1234_5678_9ABC_D000, admin_submit_base);
      chk("acq refused", 64'h0000_00AB_0000_E000, admin_complete_base);
      i_crd_host_model.access(1'b0, 1'b0, 1'b0, BASE + 64'h1_0000_0014, 64'h0, v, seen);
      chk("miss answer", 64'h0, 64'(seen[2]));
   endtask

   task automatic t_mask;
      wrr(16'h000C, 64'h0F);
      wrr(16'h0010, 64'h05);
      chk("irq mask", 64'h0A, 64'(mask));
      rdc(16'h0010, 1'b0, 64'h0A);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   // A stuck run is cut off well past the roughly 80 cycles the scenarios need.
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      i_resetn = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      t_ident();
      t_rw();
      t_ro();
      t_bell();
      t_refuse();
      t_mask();
      tally_and_finish();
   end
endmodule

`default_nettype wire
